// >>> sfm_line_model.sv
`timescale 1ns/1ps
module sfm_line_model (
    input  wire logic                        clk,
    input  wire logic                        arst_n,
    input  wire logic                        line_power_en,
    input  wire logic [sfm_pkg::NUM_CH-1:0]  line_comm_en,
    input  wire logic [sfm_pkg::NUM_CH-1:0]  unit_present,
    output logic      [sfm_pkg::NUM_CH-1:0]  ballast_answer
);
    // Units answer one cycle late and only over a powered, live line; an absent unit or an
    // open line stays silent, so the gateway cannot tell the two apart.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ballast_answer <= '0;
        end else begin
            ballast_answer <= line_comm_en & unit_present
                              & {sfm_pkg::NUM_CH{line_power_en}};
        end
    end
endmodule : sfm_line_model

// >>> sfm_pkg.sv
package sfm_pkg;

    // Number of lighting-line channels watched by the block.
    localparam int unsigned NUM_CH = 8;

    // Report mode of a fault flag on the building bus.
    typedef enum logic [1:0] {
        SFM_REP_OFF,
        SFM_REP_READ,
        SFM_REP_CHANGE
    } sfm_rep_e;

    // Output reaction applied on failure or on recovery.
    typedef enum logic [2:0] {
        SFM_REACT_NONE,
        SFM_REACT_TURN_ON,
        SFM_REACT_MAX,
        SFM_REACT_MIN,
        SFM_REACT_OFF
    } sfm_react_e;

    // Brightness command issued to a channel.
    typedef struct packed {
        logic       valid;
        logic [7:0] level;
    } sfm_level_s;

    // Fault report telegram towards the building bus.
    typedef struct packed {
        logic       valid;
        logic [1:0] kind;
        logic [2:0] chan;
        logic       value;
    } sfm_report_s;

    // Report kinds.
    localparam logic [1:0] KIND_SUPPLY  = 2'h0;
    localparam logic [1:0] KIND_LINE    = 2'h1;
    localparam logic [1:0] KIND_BALLAST = 2'h2;
    localparam logic [1:0] KIND_LAMP    = 2'h3;

    // Reset values.
    localparam logic [7:0] LEVEL_RST = 8'h00;
    localparam logic       FLAG_RST  = 1'b0;

    // Synchroniser depth for pin inputs.
    localparam int unsigned SYNC_STAGES = 3;

endpackage : sfm_pkg

// >>> sfm_supply_fault_monitor.sv
// Behaviour
// - Supply loss: operating and fault indicators off.
// - Supply absent: bus programming yes, line traffic no.
// - Supply absent: stop generating line voltage.
// - Supply flag reported on change or read.
// - Supply flag raised on AC or DC loss.
// - One acknowledge clears all fault flags.
// - Supply loss aborts test mode permanently.
// - Failure applies configured output reaction.
// - Supply loss freezes scene and dynamic sequences.
// - Supply return applies configured recovery reaction.
// - Bus failure cancels burn-in and elapsed time.
// - Line short treated like line voltage loss.
// - Open line means ballast error for silent units.
// - Acknowledged flags clear only after fault gone.
// - Unacknowledged flags send zero when fault clears.
`timescale 1ns/1ps
module sfm_supply_fault_monitor (
    input  wire logic                             clk,
    input  wire logic                             arst_n,
    input  wire logic                             supply_ok_pin,
    input  wire logic [sfm_pkg::NUM_CH-1:0]       line_short_pin,
    input  wire logic                             bus_ok_pin,
    input  wire logic [sfm_pkg::NUM_CH-1:0]       ballast_answer,
    input  wire logic [sfm_pkg::NUM_CH-1:0]       lamp_fault,
    input  wire logic [sfm_pkg::NUM_CH-1:0][7:0]  chan_level,
    input  wire logic [7:0]                       turn_on_level,
    input  wire logic [7:0]                       max_level,
    input  wire logic [7:0]                       min_level,
    input  wire sfm_pkg::sfm_react_e              fail_react,
    input  wire sfm_pkg::sfm_react_e              recover_react,
    input  wire sfm_pkg::sfm_rep_e                supply_rep_mode,
    input  wire sfm_pkg::sfm_rep_e                chan_rep_mode,
    input  wire logic                             ack_enable,
    input  wire logic                             ack_strobe,
    input  wire logic                             read_req,
    input  wire logic [1:0]                       read_kind,
    input  wire logic [2:0]                       read_chan,
    input  wire logic                             test_start,
    input  wire logic                             prog_write,
    input  wire logic                             burn_in_start,
    output logic                                  run_led,
    output logic                                  line_fault_led,
    output logic                                  line_power_en,
    output logic [sfm_pkg::NUM_CH-1:0]            line_comm_en,
    output logic                                  prog_accept,
    output logic                                  test_active,
    output logic                                  seq_freeze,
    output logic                                  burn_in_active,
    output logic                                  burn_in_clear,
    output logic                                  supply_fault_flag,
    output logic [sfm_pkg::NUM_CH-1:0]            line_fault_flag,
    output logic [sfm_pkg::NUM_CH-1:0]            ballast_fault_flag,
    output logic [sfm_pkg::NUM_CH-1:0]            lamp_fault_flag,
    output sfm_pkg::sfm_level_s [sfm_pkg::NUM_CH-1:0] chan_cmd,
    output sfm_pkg::sfm_report_s                  report
);

    localparam int unsigned NF = 1 + 3 * sfm_pkg::NUM_CH;

    // Pin synchronisers: a change is taken once stages two and three agree.
    logic [sfm_pkg::SYNC_STAGES-1:0] sup_sync_reg;
    logic [sfm_pkg::SYNC_STAGES-1:0] bus_sync_reg;
    logic [sfm_pkg::NUM_CH-1:0]      sh_s1_reg;
    logic [sfm_pkg::NUM_CH-1:0]      sh_s2_reg;
    logic [sfm_pkg::NUM_CH-1:0]      sh_s3_reg;
    logic                            supply_ok_reg;
    logic                            bus_ok_reg;
    logic [sfm_pkg::NUM_CH-1:0]      short_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sup_sync_reg <= '0;
            bus_sync_reg <= '0;
            sh_s1_reg    <= '0;
            sh_s2_reg    <= '0;
            sh_s3_reg    <= '0;
        end else begin
            sup_sync_reg <= {sup_sync_reg[1:0], supply_ok_pin};
            bus_sync_reg <= {bus_sync_reg[1:0], bus_ok_pin};
            sh_s1_reg    <= line_short_pin;
            sh_s2_reg    <= sh_s1_reg;
            sh_s3_reg    <= sh_s2_reg;
        end
    end

    // Filtered levels; each bit moves only when the last two stages agree.
    wire                       sup_agree = sup_sync_reg[2] == sup_sync_reg[1];
    wire                       bus_agree = bus_sync_reg[2] == bus_sync_reg[1];
    wire [sfm_pkg::NUM_CH-1:0] sh_agree  = ~(sh_s3_reg ^ sh_s2_reg);
    wire [sfm_pkg::NUM_CH-1:0] short_next =
        (sh_agree & sh_s3_reg) | (~sh_agree & short_reg);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            supply_ok_reg <= 1'b0;
            bus_ok_reg    <= 1'b0;
            short_reg     <= '0;
        end else begin
            supply_ok_reg <= sup_agree ? sup_sync_reg[2] : supply_ok_reg;
            bus_ok_reg    <= bus_agree ? bus_sync_reg[2] : bus_ok_reg;
            short_reg     <= short_next;
        end
    end

    // Edges of the filtered supply, bus and short levels.
    logic                       supply_d_reg;
    logic                       bus_d_reg;
    logic [sfm_pkg::NUM_CH-1:0] short_d_reg;
    logic [sfm_pkg::NUM_CH-1:0] missing_d_reg;
    wire supply_lost = supply_d_reg & ~supply_ok_reg;
    wire supply_back = ~supply_d_reg & supply_ok_reg;
    wire bus_lost    = bus_d_reg & ~bus_ok_reg;
    wire bus_back    = ~bus_d_reg & bus_ok_reg;

    // A channel's line is dead if the supply is gone or the line is shorted.
    wire [sfm_pkg::NUM_CH-1:0] line_dead = {sfm_pkg::NUM_CH{~supply_ok_reg}} | short_reg;
    wire [sfm_pkg::NUM_CH-1:0] line_dead_d = {sfm_pkg::NUM_CH{~supply_d_reg}} | short_d_reg;
    wire [sfm_pkg::NUM_CH-1:0] line_fail = line_dead & ~line_dead_d;
    wire [sfm_pkg::NUM_CH-1:0] line_back = ~line_dead & line_dead_d;
    // Silent units on a line live for two edges are ballast errors; an open line shows up
    // this way. The extra edge gives units on a freshly powered line time to answer.
    wire [sfm_pkg::NUM_CH-1:0] ballast_bad = ~line_dead & ~line_dead_d & ~ballast_answer;
    // Only a unit that was missing counts as returning, so line recovery keeps its reaction.
    wire [sfm_pkg::NUM_CH-1:0] ballast_ret = ballast_answer & missing_d_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            supply_d_reg <= 1'b0;
            bus_d_reg    <= 1'b0;
            short_d_reg  <= '0;
            missing_d_reg <= '0;
        end else begin
            supply_d_reg <= supply_ok_reg;
            bus_d_reg    <= bus_ok_reg;
            short_d_reg  <= short_reg;
            missing_d_reg <= ballast_bad;
        end
    end

    // Indicators and line power follow the supply directly.
    assign run_led        = supply_ok_reg;
    assign line_fault_led = supply_ok_reg & (|short_reg);
    assign line_power_en  = supply_ok_reg;
    assign line_comm_en   = ~line_dead;
    assign prog_accept    = prog_write;

    // Fault conditions in one vector: bit 0 supply, then line, ballast, lamp.
    wire [NF-1:0] cond = {lamp_fault & ~line_dead, ballast_bad, line_dead,
                          ~supply_ok_reg};
    logic [NF-1:0] flag_reg;
    logic [NF-1:0] flag_next;
    logic [NF-1:0] sent_reg;

    // A set beats an acknowledge; latched flags need fault gone and ack.
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++) begin : g_flag
            wire clr_ok = ack_enable ? (ack_strobe & ~cond[gi])
                                     : ~cond[gi];
            assign flag_next[gi] = cond[gi] | (flag_reg[gi] & ~clr_ok);
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= {NF{sfm_pkg::FLAG_RST}};
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign supply_fault_flag  = flag_reg[0];
    assign line_fault_flag    = flag_reg[sfm_pkg::NUM_CH:1];
    assign ballast_fault_flag = flag_reg[2*sfm_pkg::NUM_CH:sfm_pkg::NUM_CH+1];
    assign lamp_fault_flag    = flag_reg[NF-1:2*sfm_pkg::NUM_CH+1];

    // Spontaneous reporting: pending bits differ from the value last sent.
    // Reports wait for the building bus; changes while it is down are sent later.
    wire [NF-1:0] rep_en;
    assign rep_en[0]    = supply_rep_mode == sfm_pkg::SFM_REP_CHANGE;
    assign rep_en[NF-1:1] = {(NF-1){chan_rep_mode == sfm_pkg::SFM_REP_CHANGE}};
    wire [NF-1:0] pend = (flag_reg ^ sent_reg) & rep_en;
    logic [4:0] pick;
    always_comb begin
        pick = '0;
        for (int i = NF - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick = 5'(i);
            end
        end
    end
    wire chg_go  = bus_ok_reg & (|pend);
    wire [4:0] rd_idx = (read_kind == sfm_pkg::KIND_SUPPLY) ? 5'h00 :
                        5'(1 + int'(read_kind - 2'h1) * sfm_pkg::NUM_CH + int'(read_chan));
    wire rd_allowed = (read_kind == sfm_pkg::KIND_SUPPLY) ?
                      (supply_rep_mode != sfm_pkg::SFM_REP_OFF) :
                      (chan_rep_mode != sfm_pkg::SFM_REP_OFF);
    wire rd_go   = bus_ok_reg & read_req & rd_allowed & ~chg_go;
    wire [4:0] ridx = chg_go ? pick : rd_idx;
    wire [1:0] rkind = (ridx == 5'h00) ? sfm_pkg::KIND_SUPPLY :
                       2'((int'(ridx) - 1) / sfm_pkg::NUM_CH + 1);
    wire [2:0] rchan = (ridx == 5'h00) ? 3'h0 : 3'((int'(ridx) - 1) % sfm_pkg::NUM_CH);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sent_reg <= '0;
            report   <= '0;
        end else begin
            if (chg_go) begin
                sent_reg[pick] <= flag_reg[pick];
            end
            report.valid <= chg_go | rd_go;
            report.kind  <= rkind;
            report.chan  <= rchan;
            report.value <= flag_reg[ridx];
        end
    end

    // Test mode is dropped on supply loss and never comes back alone.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_active <= 1'b0;
        end else if (!supply_ok_reg) begin
            test_active <= 1'b0;
        end else if (test_start) begin
            test_active <= 1'b1;
        end
    end

    // Sequences freeze on supply loss and resume on supply or bus return;
    // with no-change selected a bus failure leaves them running.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_freeze <= 1'b0;
        end else if (supply_lost) begin
            seq_freeze <= 1'b1;
        end else if (bus_lost && fail_react != sfm_pkg::SFM_REACT_NONE) begin
            seq_freeze <= 1'b1;
        end else if (supply_back || bus_back) begin
            seq_freeze <= 1'b0;
        end
    end

    // Burn-in is cancelled by a bus failure; elapsed time is discarded.
    assign burn_in_clear = bus_lost | supply_lost;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            burn_in_active <= 1'b0;
        end else if (burn_in_clear) begin
            burn_in_active <= 1'b0;
        end else if (burn_in_start && bus_ok_reg) begin
            burn_in_active <= 1'b1;
        end
    end

    // Maps a reaction choice onto a level; none means no command.
    function automatic sfm_pkg::sfm_level_s react_level(input sfm_pkg::sfm_react_e r);
        sfm_pkg::sfm_level_s v;
        v.valid = 1'b1;
        v.level = sfm_pkg::LEVEL_RST;
        unique case (r)
            sfm_pkg::SFM_REACT_NONE:    v.valid = 1'b0;
            sfm_pkg::SFM_REACT_TURN_ON: v.level = turn_on_level;
            sfm_pkg::SFM_REACT_MAX:     v.level = max_level;
            sfm_pkg::SFM_REACT_MIN:     v.level = min_level;
            sfm_pkg::SFM_REACT_OFF:     v.level = sfm_pkg::LEVEL_RST;
            default:                    v.valid = 1'b0;
        endcase
        return v;
    endfunction : react_level

    // Per-channel output commands, one-cycle pulses from flip-flops.
    wire sfm_pkg::sfm_level_s fail_cmd = react_level(fail_react);
    wire sfm_pkg::sfm_level_s back_cmd = react_level(recover_react);
    generate
        for (gi = 0; gi < sfm_pkg::NUM_CH; gi++) begin : g_cmd
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    chan_cmd[gi] <= '0;
                end else if (line_fail[gi] || bus_lost) begin
                    chan_cmd[gi] <= fail_cmd;
                end else if (line_back[gi] || bus_back) begin
                    chan_cmd[gi] <= back_cmd;
                end else if (ballast_ret[gi]) begin
                    chan_cmd[gi] <= '{valid: 1'b1, level: chan_level[gi]};
                end else begin
                    chan_cmd[gi] <= '0;
                end
            end
        end
    endgenerate

endmodule : sfm_supply_fault_monitor

// >>> sfm_supply_fault_monitor_assertions.sv
`timescale 1ns/1ps
module sfm_supply_fault_monitor_assertions (
    input wire logic                        clk,
    input wire logic                        arst_n,
    input wire logic                        prog_write,
    input wire sfm_pkg::sfm_react_e         fail_react,
    input wire logic                        ack_enable,
    input wire logic                        ack_strobe,
    input wire logic                        run_led,
    input wire logic                        line_fault_led,
    input wire logic                        line_power_en,
    input wire logic [sfm_pkg::NUM_CH-1:0]  line_comm_en,
    input wire logic                        prog_accept,
    input wire logic                        test_active,
    input wire logic                        seq_freeze,
    input wire logic                        burn_in_active,
    input wire logic                        burn_in_clear,
    input wire logic                        supply_fault_flag
);
    // One clock domain, so clocking and reset qualification are shared.
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Indicators and line power follow the filtered supply.
    dark_led_a: assert property (!run_led |-> !line_fault_led)
        else $error("line fault led lit while supply is off");
    line_power_a: assert property (line_power_en == run_led)
        else $error("line power differs from supply state");
    comm_gate_a: assert property (!line_power_en |-> line_comm_en == '0)
        else $error("line traffic enabled without supply");
    prog_pass_a: assert property (prog_accept == prog_write)
        else $error("programming write not accepted");
    // Supply loss consequences appear one edge after the indicator drops.
    flag_raise_a: assert property ($fell(run_led) |=> supply_fault_flag)
        else $error("supply fault flag not raised");
    test_abort_a: assert property ($fell(run_led) |=> !test_active)
        else $error("test mode survived supply loss");
    seq_stop_a: assert property (
        $fell(run_led) && fail_react != sfm_pkg::SFM_REACT_NONE |=> seq_freeze)
        else $error("sequences not frozen on supply loss");
    burn_drop_a: assert property (burn_in_clear |=> !burn_in_active)
        else $error("burn-in still active after clear");
    // Flag lifetime depends on the acknowledge mode.
    ack_hold_a: assert property (
        ack_enable && supply_fault_flag && !ack_strobe |=> supply_fault_flag)
        else $error("supply flag dropped without acknowledge");
    auto_clear_a: assert property (
        !ack_enable && run_led && $past(run_led) |=> !supply_fault_flag)
        else $error("supply flag kept after supply returned");
endmodule : sfm_supply_fault_monitor_assertions

bind sfm_supply_fault_monitor
    sfm_supply_fault_monitor_assertions u_sfm_supply_fault_monitor_assertions (
    .clk, .arst_n, .prog_write, .fail_react, .ack_enable, .ack_strobe, .run_led,
    .line_fault_led, .line_power_en, .line_comm_en, .prog_accept, .test_active,
    .seq_freeze, .burn_in_active, .burn_in_clear, .supply_fault_flag
);

// >>> sfm_supply_fault_monitor_tb.sv
`timescale 1ns/1ps
module sfm_supply_fault_monitor_tb;
    typedef struct {sfm_pkg::sfm_react_e react; logic cmd; logic [7:0] lvl;} sfm_row_s;
    logic                               clk = 1'b0, arst_n = 1'b0, supply_ok_pin = 1'b1;
    logic                               bus_ok_pin = 1'b1, ack_enable = 1'b0, ack_strobe = 1'b0;
    logic                               read_req = 1'b0, test_start = 1'b0, prog_write = 1'b0;
    logic                               burn_in_start = 1'b0;
    logic [sfm_pkg::NUM_CH-1:0]         line_short_pin = '0, lamp_fault = '0, unit_present = '1;
    logic [sfm_pkg::NUM_CH-1:0][7:0]    chan_level = {8{8'h5a}};
    logic [7:0]                         turn_on_level = 8'h80, max_level = 8'hfe;
    logic [7:0]                         min_level = 8'h10;
    logic [1:0]                         read_kind = 2'h0;
    logic [2:0]                         read_chan = 3'h0;
    sfm_pkg::sfm_react_e                fail_react = sfm_pkg::SFM_REACT_NONE, recover_react;
    sfm_pkg::sfm_rep_e                  supply_rep_mode = sfm_pkg::SFM_REP_CHANGE;
    sfm_pkg::sfm_rep_e                  chan_rep_mode = sfm_pkg::SFM_REP_CHANGE;
    logic                               run_led, line_fault_led, line_power_en, prog_accept;
    logic                               test_active, seq_freeze, burn_in_active, burn_in_clear;
    logic                               supply_fault_flag;
    logic [sfm_pkg::NUM_CH-1:0]         ballast_answer, line_comm_en, line_fault_flag;
    logic [sfm_pkg::NUM_CH-1:0]         ballast_fault_flag, lamp_fault_flag;
    sfm_pkg::sfm_level_s [sfm_pkg::NUM_CH-1:0] chan_cmd;
    sfm_pkg::sfm_report_s               report;
    int                                 mismatches = 0, tests_run = 0, i, k;
    sfm_row_s rows [5] = '{'{sfm_pkg::SFM_REACT_NONE, 1'b0, 8'h00},
        '{sfm_pkg::SFM_REACT_TURN_ON, 1'b1, 8'h80}, '{sfm_pkg::SFM_REACT_MAX, 1'b1, 8'hfe},
        '{sfm_pkg::SFM_REACT_MIN, 1'b1, 8'h10}, '{sfm_pkg::SFM_REACT_OFF, 1'b1, 8'h00}};

    sfm_supply_fault_monitor u_sfm_supply_fault_monitor (.clk, .arst_n, .supply_ok_pin,
        .line_short_pin, .bus_ok_pin, .ballast_answer, .lamp_fault, .chan_level, .turn_on_level,
        .max_level, .min_level, .fail_react, .recover_react, .supply_rep_mode, .chan_rep_mode,
        .ack_enable, .ack_strobe, .read_req, .read_kind, .read_chan, .test_start, .prog_write,
        .burn_in_start, .run_led, .line_fault_led, .line_power_en, .line_comm_en, .prog_accept,
        .test_active, .seq_freeze, .burn_in_active, .burn_in_clear, .supply_fault_flag,
        .line_fault_flag, .ballast_fault_flag, .lamp_fault_flag, .chan_cmd, .report);
    sfm_line_model u_sfm_line_model (.clk, .arst_n, .line_power_en, .line_comm_en,
        .unit_present, .ballast_answer);

    // Free-running clock at 25 MHz.
    always #20 clk = ~clk;

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("Checks made %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    // The pin filter takes a few edges, so the indicator is polled with a bound.
    task automatic wait_led(logic v);
        for (k = 0; k < 20 && run_led !== v; k++) begin
            @(posedge clk);
            #1;
        end
        check("run_led wait", run_led, v);
        if (run_led !== v) finish_test();
    endtask : wait_led

    initial begin
        recover_react = sfm_pkg::SFM_REACT_NONE;
        // A reset level set at time zero may raise no event, so outputs are read after an edge.
        @(posedge clk);
        #1;
        check("reset outputs", {run_led, line_power_en, line_comm_en, supply_fault_flag}, 0);
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        wait_led(1'b1);
        // Every failure and recovery reaction, with test mode running when the supply drops.
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            fail_react <= rows[i].react;
            recover_react <= rows[i].react;
            supply_ok_pin <= 1'b0;
            test_start <= 1'b1;
            @(posedge clk);
            test_start <= 1'b0;
            wait_led(1'b0);
            @(posedge clk);
            #1;
            check("fail cmd", {chan_cmd[0].valid, rows[i].cmd ? chan_cmd[0].level : 8'h00},
                  {rows[i].cmd, rows[i].lvl});
            check("supply flag", supply_fault_flag, 1);
            check("test abort", test_active, 0);
            if (rows[i].cmd) check("freeze", seq_freeze, 1);
            check("line dead", {line_power_en, line_comm_en}, 0);
            @(posedge clk);
            #1;
            check("fail report", {report.valid, report.kind, report.value}, 4'b1001);
            @(posedge clk);
            supply_ok_pin <= 1'b1;
            wait_led(1'b1);
            @(posedge clk);
            #1;
            check("recover cmd", {chan_cmd[0].valid, rows[i].cmd ? chan_cmd[0].level : 8'h00},
                  {rows[i].cmd, rows[i].lvl});
            @(posedge clk);
            #1;
            check("zero report", {report.valid, report.kind, report.value}, 4'b1000);
            repeat (8) @(posedge clk);
            $display("Reaction row %0d done", i);
        end
        // Line short on channel 1 while the supply is present.
        line_short_pin[1] <= 1'b1;
        repeat (7) @(posedge clk);
        #1;
        check("short", {line_comm_en[1], line_fault_flag[1], line_fault_led}, 3'b011);
        @(posedge clk);
        line_short_pin[1] <= 1'b0;
        // Acknowledge mode: flags outlive the fault until one acknowledge clears them all.
        repeat (8) @(posedge clk);
        ack_enable <= 1'b1;
        supply_ok_pin <= 1'b0;
        prog_write <= 1'b1;
        wait_led(1'b0);
        check("prog accept", prog_accept, 1);
        @(posedge clk);
        prog_write <= 1'b0;
        supply_ok_pin <= 1'b1;
        wait_led(1'b1);
        repeat (6) @(posedge clk);
        #1;
        check("held flags", {supply_fault_flag, line_fault_flag}, 9'h1ff);
        @(posedge clk);
        ack_strobe <= 1'b1;
        @(posedge clk);
        ack_strobe <= 1'b0;
        @(posedge clk);
        #1;
        check("acked", {supply_fault_flag, line_fault_flag, ballast_fault_flag}, 0);
        check("ack report", {report.valid, report.kind, report.value}, 4'b1000);
        @(posedge clk);
        ack_enable <= 1'b0;
        $display("Acknowledge test done");
        // Open line on channel 2, then the unit answers again.
        repeat (8) @(posedge clk);
        unit_present[2] <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check("open line", ballast_fault_flag[2], 1);
        @(posedge clk);
        unit_present[2] <= 1'b1;
        #1;
        for (k = 0; k < 8 && chan_cmd[2].valid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("return level", {chan_cmd[2].valid, chan_cmd[2].level}, 9'h15a);
        // Read-only reporting answers a read request.
        @(posedge clk);
        supply_rep_mode <= sfm_pkg::SFM_REP_READ;
        read_req <= 1'b1;
        @(posedge clk);
        read_req <= 1'b0;
        #1;
        for (k = 0; k < 4 && report.valid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check("read report", {report.valid, report.kind, report.value}, 4'b1000);
        // A lamp fault on channel 3 is flagged and reported with its channel number.
        @(posedge clk);
        lamp_fault[3] <= 1'b1;
        @(posedge clk);
        #1;
        check("lamp flag", lamp_fault_flag, 8'h08);
        @(posedge clk);
        #1;
        check("lamp report", {report.valid, report.kind, report.chan, report.value}, 7'h77);
        // Burn-in is discarded by a bus failure and stays off after recovery.
        @(posedge clk);
        burn_in_start <= 1'b1;
        lamp_fault[3] <= 1'b0;
        @(posedge clk);
        burn_in_start <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("burn start", burn_in_active, 1);
        @(posedge clk);
        bus_ok_pin <= 1'b0;
        repeat (8) @(posedge clk);
        bus_ok_pin <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check("burn lost", burn_in_active, 0);
        $display("Line and burn-in tests done");
        finish_test();
    end
endmodule : sfm_supply_fault_monitor_tb
